// >>> verilog/lsv_top.sv
// Windowed lockup supervisor with APB registers
// How it works
// (RQ1) A 12-bit down-counter steps on each tick of a 3-bit prescaler.
// (RQ2) Counting below zero without reload fires a system reset.
// (RQ3) Reload while count still above delta also fires a system reset.
// (RQ4) Delta, the window's upper limit, lives in its own register.
// (RQ5) Optionally the counter freezes while the processor is in debug.
// (RQ6) With protection on, configuration writes are ignored.
// (RQ7) Clock source is internal or external slow oscillator, selectable.
// (RQ8) An accepted reload restores the reload value on the next tick.
//
// The APB interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`include "lsv_regs.svh"
module lsv_top (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        slow_internal_osc,
    input  wire logic        slow_external_osc,
    input  wire logic        cpu_halted,
    output logic             sys_reset_req
);
    lsv_pkg::lsv_cfg_t   cfg_r;
    lsv_pkg::lsv_state_t state_r;
    logic [11:0] count_r;
    logic        locked_r;
    logic        reload_pend_r;
    logic        early_r;
    logic        under_r;
    logic [3:0]  pulse_r;
    logic        tick;
    logic        frozen;
    logic        wr_acc;
    logic        known;
    logic        cfg_wr;
    logic        reload_wr;
    logic        reload_hit;
    logic        early_hit;
    logic        under_hit;

    ////////////////////////////////////////////////////////////////
    // Bus decode; slave answers in the access cycle, no wait states
    function automatic logic is_ofs(input logic [11:0] a, input logic [11:0] o);
        return {a[11:2], 2'b00} == o;
    endfunction

    assign wr_acc    = psel & penable & pwrite & (pstrb == 4'hf);
    assign known     = is_ofs(paddr, `LSV_CTRL_OFS) | is_ofs(paddr, `LSV_MODE_OFS)
                     | is_ofs(paddr, `LSV_DELTA_OFS) | is_ofs(paddr, `LSV_STAT_OFS)
                     | is_ofs(paddr, `LSV_PROT_OFS);
    assign cfg_wr    = wr_acc & ~locked_r; // RQ6
    assign reload_wr = wr_acc & is_ofs(paddr, `LSV_CTRL_OFS)
                     & (pwdata[15:0] == `LSV_CTRL_RELOAD_KEY);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & ~known;
            prdata  <= 32'h0000_0000;
            if (psel & ~penable & ~pwrite) begin
                if (is_ofs(paddr, `LSV_MODE_OFS)) begin
                    prdata <= {14'h0000, cfg_r.src_ext, cfg_r.dbg_hold, cfg_r.pre,
                               cfg_r.en, cfg_r.reload};
                end else if (is_ofs(paddr, `LSV_DELTA_OFS)) begin
                    prdata <= {20'h00000, cfg_r.delta};
                end else if (is_ofs(paddr, `LSV_STAT_OFS)) begin
                    prdata <= {14'h0000, early_r, under_r, 4'h0, count_r};
                end else if (is_ofs(paddr, `LSV_PROT_OFS)) begin
                    prdata <= {31'h0000_0000, locked_r};
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // Configuration and protection
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            locked_r <= 1'b0;
        end else if (wr_acc & pready & is_ofs(paddr, `LSV_PROT_OFS)) begin
            if (pwdata[15:0] == `LSV_PROT_UNLOCK_KEY) begin
                locked_r <= 1'b0;
            end else if (pwdata[15:0] == `LSV_PROT_LOCK_KEY) begin
                locked_r <= 1'b1; // RQ6
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_r.en       <= 1'b0;
            cfg_r.pre      <= `LSV_PRE_RST;
            cfg_r.dbg_hold <= 1'b0;
            cfg_r.src_ext  <= 1'b0;
            cfg_r.reload   <= `LSV_RELOAD_RST;
            cfg_r.delta    <= `LSV_DELTA_RST;
        end else if (cfg_wr & pready) begin
            if (is_ofs(paddr, `LSV_MODE_OFS)) begin
                cfg_r.reload   <= pwdata[11:0];
                cfg_r.en       <= pwdata[`LSV_MODE_EN_BIT];
                cfg_r.pre      <= pwdata[`LSV_MODE_PRE_LSB +: 3];
                cfg_r.dbg_hold <= pwdata[`LSV_MODE_DBG_BIT]; // RQ5
                cfg_r.src_ext  <= pwdata[`LSV_MODE_SRC_BIT]; // RQ7
            end else if (is_ofs(paddr, `LSV_DELTA_OFS)) begin
                cfg_r.delta    <= pwdata[11:0]; // RQ4
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // Prescaler and tick
    assign frozen = cfg_r.dbg_hold & cpu_halted; // RQ5

    lsv_tick u_tick (
        .pclk              (pclk),
        .presetn           (presetn),
        .slow_internal_osc (slow_internal_osc),
        .slow_external_osc (slow_external_osc),
        .src_ext           (cfg_r.src_ext),
        .pre               (cfg_r.pre),
        .run               (cfg_r.en & ~frozen & (state_r == lsv_pkg::LSV_RUN)),
        .tick              (tick)
    );

    ////////////////////////////////////////////////////////////////
    // Counter and window check
    assign reload_hit = reload_wr & pready & (state_r == lsv_pkg::LSV_RUN);
    assign early_hit  = reload_hit & (count_r > cfg_r.delta); // RQ3
    assign under_hit  = (state_r == lsv_pkg::LSV_RUN) & tick & ~reload_pend_r
                      & (count_r == 12'h000); // RQ2

    // Only presetn leaves FIRE, so a wedged program cannot cancel the reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= lsv_pkg::LSV_IDLE;
        end else begin
            unique case (state_r)
                lsv_pkg::LSV_IDLE: begin
                    if (cfg_r.en) begin
                        state_r <= lsv_pkg::LSV_RUN;
                    end
                end
                lsv_pkg::LSV_RUN: begin
                    if (early_hit | under_hit) begin
                        state_r <= lsv_pkg::LSV_FIRE;
                    end else if (!cfg_r.en) begin
                        state_r <= lsv_pkg::LSV_IDLE;
                    end
                end
                lsv_pkg::LSV_FIRE: begin
                    state_r <= lsv_pkg::LSV_FIRE;
                end
            endcase
        end
    end

    // Idle keeps the counter primed with the reload value
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_r <= `LSV_RELOAD_RST;
        end else if (state_r == lsv_pkg::LSV_IDLE) begin
            count_r <= cfg_r.reload;
        end else if (state_r == lsv_pkg::LSV_RUN && tick && !under_hit) begin
            if (reload_pend_r) begin
                count_r <= cfg_r.reload; // RQ8
            end else begin
                count_r <= count_r - 12'h001; // RQ1
            end
        end
    end

    // Set beats clear: a reload on the applying tick is kept for the next
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reload_pend_r <= 1'b0;
        end else if (state_r != lsv_pkg::LSV_RUN) begin
            reload_pend_r <= 1'b0;
        end else if (reload_hit & ~early_hit) begin
            reload_pend_r <= 1'b1;
        end else if (tick) begin
            reload_pend_r <= 1'b0;
        end
    end

    // Cause flags stay until presetn so software can read why it fired
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            early_r <= 1'b0;
            under_r <= 1'b0;
        end else begin
            if (early_hit) begin
                early_r <= 1'b1; // RQ3
            end
            if (under_hit) begin
                under_r <= 1'b1; // RQ2
            end
        end
    end

    // Reset request held a fixed pulse width; system reset clears the block
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pulse_r       <= 4'h0;
            sys_reset_req <= 1'b0;
        end else begin
            if (state_r == lsv_pkg::LSV_FIRE && pulse_r != 4'(`LSV_RST_PULSE_CYC)) begin
                pulse_r <= pulse_r + 4'h1;
            end
            sys_reset_req <= (state_r == lsv_pkg::LSV_FIRE)
                           && pulse_r != 4'(`LSV_RST_PULSE_CYC); // RQ2
        end
    end
endmodule

// >>> verilog/lsv_regs.svh
// Register offsets, field positions, reset values and timing counts of the lockup supervisor
`ifndef LSV_REGS_SVH
`define LSV_REGS_SVH

`define LSV_CTRL_OFS        12'h000
`define LSV_MODE_OFS        12'h004
`define LSV_DELTA_OFS       12'h008
`define LSV_STAT_OFS        12'h00c
`define LSV_PROT_OFS        12'h010

`define LSV_CTRL_RELOAD_KEY 16'hca35
`define LSV_PROT_UNLOCK_KEY 16'h35ca
`define LSV_PROT_LOCK_KEY   16'h0001

`define LSV_MODE_EN_BIT     12
`define LSV_MODE_PRE_LSB    13
`define LSV_MODE_DBG_BIT    16
`define LSV_MODE_SRC_BIT    17

`define LSV_RELOAD_RST      12'hfff
`define LSV_DELTA_RST       12'hfff
`define LSV_PRE_RST         3'h0

`define LSV_RST_PULSE_NS    64
`define LSV_RST_PULSE_CYC   ((`LSV_RST_PULSE_NS + 7) / 8)

`endif

// >>> verilog/lsv_pkg.sv
// Types shared by the lockup supervisor files
package lsv_pkg;
    typedef struct packed {
        logic        en;
        logic [2:0]  pre;
        logic        dbg_hold;
        logic        src_ext;
        logic [11:0] reload;
        logic [11:0] delta;
    } lsv_cfg_t;

    typedef enum logic [2:0] {
        LSV_IDLE = 3'b001,
        LSV_RUN  = 3'b010,
        LSV_FIRE = 3'b100
    } lsv_state_t;
endpackage

// >>> verilog/lsv_tick.sv
// Oscillator select and 3-bit prescaler producing the count tick
`timescale 1ns/1ps
module lsv_tick (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       slow_internal_osc,
    input  wire logic       slow_external_osc,
    input  wire logic       src_ext,
    input  wire logic [2:0] pre,
    input  wire logic       run,
    output logic            tick
);
    logic       osc_d_r;
    logic [6:0] div_r;
    logic       osc;
    logic       edge_seen;

    assign osc = src_ext ? slow_external_osc : slow_internal_osc;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osc_d_r <= 1'b0;
        end else begin
            osc_d_r <= osc;
        end
    end

    assign edge_seen = osc & ~osc_d_r;

    // Division by 2^pre of the selected slow oscillator
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_r <= 7'h00;
            tick  <= 1'b0;
        end else begin
            tick <= 1'b0;
            if (!run) begin
                div_r <= 7'h00;
            end else if (edge_seen) begin // RQ1
                if (div_r >= 7'((8'h01 << pre) - 8'h01)) begin
                    div_r <= 7'h00;
                    tick  <= 1'b1;
                end else begin
                    div_r <= div_r + 7'h01;
                end
            end
        end
    end
endmodule

// >>> sim/lsv_top_sva.sv
// Port checker for the lockup supervisor
`timescale 1ns/1ps
`include "lsv_regs.svh"
module lsv_top_sva (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        sys_reset_req
);
    logic fired_r;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Only a fresh presetn may rearm the pulse
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fired_r <= 1'h0;
        end else if ($fell(sys_reset_req)) begin
            fired_r <= 1'h1;
        end
    end
    wait_state_a: assert property (psel && !penable |=> pready)
        else $error("access phase length wrong");
    ready_cause_a: assert property (pready |-> psel && penable)
        else $error("ready without access");
    ready_once_a: assert property (pready |=> !pready)
        else $error("ready held too long");
    err_range_a: assert property (pready |-> pslverr == ({paddr[11:2], 2'b00} > `LSV_PROT_OFS))
        else $error("error flag wrong for address");
    err_zero_a: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
        else $error("refused read returned data");
    err_only_a: assert property (pslverr |-> pready)
        else $error("error without ready");
    pulse_len_a: assert property ($rose(sys_reset_req) |-> sys_reset_req[*8] ##1 !sys_reset_req)
        else $error("reset pulse length wrong");
    fire_once_a: assert property (fired_r |-> !sys_reset_req)
        else $error("second reset pulse");
endmodule
////////////////////////////////////////////////////////////////////////////////
bind lsv_top lsv_top_sva u_sva (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sys_reset_req(sys_reset_req)
);

// >>> sim/lsv_top_tb.sv
// Self-checking bench for the lockup supervisor
`timescale 1ns/1ps
`include "lsv_regs.svh"
module lsv_top_tb;
    logic        pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0;
    logic        pwrite = 1'h0, osc_i = 1'h0, osc_e = 1'h0, halt = 1'h0;
    logic [3:0]  strb = 4'hf;
    logic        pready, pslverr, sys_reset_req, err;
    logic [11:0] paddr = 12'h0, cnt;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    int          failures = 0, check_count = 0, cyc = 0;
    lsv_top dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(strb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .slow_internal_osc(osc_i), .slow_external_osc(osc_e),
        .cpu_halted(halt), .sys_reset_req(sys_reset_req)
    );
    always #4 pclk = ~pclk;
    // Oscillators rise every 4 and 6 cycles, so the source shows in the rate
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        osc_i <= (cyc % 4) > 1;
        osc_e <= (cyc % 6) > 2;
        if (cyc == 20000) begin
            failures++;
            test_done();
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Idle edge after each transfer keeps one assignment per signal per step
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do @(posedge pclk); while (pready !== 1'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge pclk);
    endtask
    task automatic fire(input int lim);
        int n;
        n = 0;
        while (sys_reset_req !== 1'h1 && n < lim) begin
            @(posedge pclk);
            n++;
        end
        chk(sys_reset_req, 1'h1);
    endtask
    task automatic rst();
        presetn <= 1'h0;
        repeat (12) @(posedge pclk);
        presetn <= 1'h1;
        @(posedge pclk);
    endtask
    task automatic t_lock();
        apb(1'h0, `LSV_MODE_OFS, 32'h0);
        chk(rd, 32'h0000_0fff);
        apb(1'h0, 12'h020, 32'h0);
        chk(err, 1'h1);
        chk(rd, 32'h0000_0000);
        apb(1'h1, `LSV_DELTA_OFS, 32'h0000_0abc);
        apb(1'h1, `LSV_PROT_OFS, 32'h0000_0001);
        apb(1'h0, `LSV_PROT_OFS, 32'h0);
        chk(rd[0], 1'h1);
        apb(1'h1, `LSV_DELTA_OFS, 32'h0000_0123);
        apb(1'h1, `LSV_MODE_OFS, 32'h0000_1001);
        apb(1'h0, `LSV_DELTA_OFS, 32'h0);
        chk(rd, 32'h0000_0abc);
        apb(1'h0, `LSV_MODE_OFS, 32'h0);
        chk(rd, 32'h0000_0fff);
        apb(1'h1, `LSV_PROT_OFS, 32'h0000_35ca);
        apb(1'h1, `LSV_DELTA_OFS, 32'h0000_000c);
        apb(1'h0, `LSV_DELTA_OFS, 32'h0);
        chk(rd, 32'h0000_000c);
        // Partial strobes must leave the register alone
        strb <= 4'h3;
        apb(1'h1, `LSV_DELTA_OFS, 32'h0000_0123);
        strb <= 4'hf;
        apb(1'h0, `LSV_DELTA_OFS, 32'h0);
        chk(rd, 32'h0000_000c);
        $display("test lock done");
    endtask
    task automatic t_window();
        apb(1'h1, `LSV_MODE_OFS, 32'h0000_1010);
        cnt = 12'hfff;
        while (cnt >= 12'h00c) begin
            apb(1'h0, `LSV_STAT_OFS, 32'h0);
            cnt = rd[11:0];
        end
        apb(1'h1, `LSV_CTRL_OFS, 32'h0000_ca35);
        repeat (4) @(posedge pclk);
        apb(1'h0, `LSV_STAT_OFS, 32'h0);
        chk(rd[11:0] > 12'h00d, 1'h1);
        chk(sys_reset_req, 1'h0);
        apb(1'h1, `LSV_MODE_OFS, 32'h0000_0fff);
        $display("test window done");
    endtask
    task automatic t_debug();
        apb(1'h1, `LSV_MODE_OFS, 32'h0003_1040);
        repeat (12) @(posedge pclk);
        halt <= 1'h1;
        repeat (8) @(posedge pclk);
        apb(1'h0, `LSV_STAT_OFS, 32'h0);
        cnt = rd[11:0];
        repeat (40) @(posedge pclk);
        apb(1'h0, `LSV_STAT_OFS, 32'h0);
        chk(rd[11:0], cnt);
        halt <= 1'h0;
        repeat (40) @(posedge pclk);
        apb(1'h0, `LSV_STAT_OFS, 32'h0);
        cnt = cnt - rd[11:0];
        chk(cnt >= 12'h006 && cnt <= 12'h007, 1'h1);
        apb(1'h1, `LSV_MODE_OFS, 32'h0000_0fff);
        $display("test debug done");
    endtask
    task automatic t_fire(input logic [31:0] mode, input logic early);
        // Reset widens delta to full range, which would accept any reload
        apb(1'h1, `LSV_DELTA_OFS, 32'h0000_000c);
        apb(1'h1, `LSV_MODE_OFS, mode);
        if (early) begin
            apb(1'h1, `LSV_CTRL_OFS, 32'h0000_ca35);
            fire(6);
        end else begin
            repeat (50) @(posedge pclk);
            chk(sys_reset_req, 1'h0);
            fire(60);
        end
        apb(1'h0, `LSV_STAT_OFS, 32'h0);
        chk(rd[17:16], {early, !early});
        rst();
        $display("test fire done");
    endtask
    task automatic test_done();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        rst();
        t_lock();
        t_window();
        t_debug();
        t_fire(32'h0000_3008, 1'h0);
        t_fire(32'h0000_1020, 1'h1);
        test_done();
    end
endmodule
